// >>> src/pio_defines.vh
`ifndef PIO_DEFINES_VH
`define PIO_DEFINES_VH

// ----------------------------------------
// geometry
// ----------------------------------------
`define PIO_NGRP 11
`define PIO_NPIN 88
`define PIO_NPU 22
`define PIO_IN_ONLY 85

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define PIO_DIR_BASE 8'h00
`define PIO_LAT_BASE 8'h40
`define PIO_PU_ADDR 8'h80
`define PIO_PCTL_ADDR 8'h84
`define PIO_MODE_ADDR 8'h88
`define PIO_REGION_DIR 2'h0
`define PIO_REGION_LAT 2'h1
`define PIO_REGION_MISC 2'h2

// ----------------------------------------
// fields
// ----------------------------------------
`define PIO_PCTL_P1LAT 0
`define PIO_MODE_MEXP 0
`define PIO_MODE_BUS8 1
`define PIO_MODE_P1MUX 2
`define PIO_PORT_ONE 1

// ----------------------------------------
// masks and reset values
// ----------------------------------------
`define PIO_EXTBUS_MASK 88'h00_0000_0000_FFFF_FFFF_FFFF
`define PIO_PU_INV_MASK 22'h00_0DFF
`define PIO_DIR_RST 8'h00
`define PIO_LAT_RST 8'h00
`define PIO_PU_RST 22'h00_0000
`define PIO_PCTL_RST 1'b0
`define PIO_MODE_RST 3'h0

`endif

// >>> src/pio_rst_sync.v
`timescale 1ns/100ps
// ----------------------------------------
// reset release synchroniser
// ----------------------------------------
module pio_rst_sync
(
  // clock and raw reset
  input wire mclk_i,
  input wire arst_n_i,
  // synchronised reset
  output wire rst_n_o
);

  reg meta_r;
  reg sync_r;

  // assert at once, release two edges later
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end
    else
    begin
      meta_r <= 1'b1;
      sync_r <= meta_r;
    end
  end

  assign rst_n_o = sync_r;

endmodule

// >>> src/pio_pin_cell.v
`timescale 1ns/100ps
// ----------------------------------------
// one pin: drive, enable, pull-up, read path
// ----------------------------------------
module pio_pin_cell
#(
  parameter INPUT_ONLY = 0
)
(
  // clock and reset
  input wire mclk_i,
  input wire rst_n_i,
  // register state
  input wire dir_i,
  input wire lat_i,
  input wire pu_en_i,
  input wire force_lat_i,
  // peripheral override
  input wire per_oe_i,
  input wire per_out_i,
  // pad
  input wire pin_i,
  output reg pad_out_o,
  output reg pad_oe_o,
  output reg pad_pu_o,
  // read value
  output wire rdval_o
);

  wire drive;

  // peripheral output wins over the direction bit
  assign drive = (INPUT_ONLY != 0) ? 1'b0 : (dir_i | per_oe_i);

  // outputs read the latch, inputs the pin
  assign rdval_o = (force_lat_i | drive) ? lat_i : pin_i;

  // pad signals are registered so outputs come from flops
  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pad_out_o <= 1'b0;
      pad_oe_o <= 1'b0;
      pad_pu_o <= 1'b0;
    end
    else
    begin
      pad_out_o <= per_oe_i ? per_out_i : lat_i;
      pad_oe_o <= drive;
      pad_pu_o <= pu_en_i & ~drive & (INPUT_ONLY == 0);
    end
  end

endmodule

// >>> src/pio_top.v
`timescale 1ns/100ps
`include "pio_defines.vh"
// Summary of operation
// - 87 bidirectional pins, groups zero to ten
// - one direction bit per pin
// - input-only pin: no direction, no pull-up
// - pull-up enable per group of four
// - pull-up only while pin is input
// - peripheral output overrides direction bit
// - expansion mode locks bus pin direction bits
// - expansion mode locks bus pin latches
// - latch drives, read path samples pin for inputs, latch for outputs
// - expansion mode: pull-up bits writable; bus bits 0-11 disconnected except bit 9
// - port-control bit 0 selects port one read
// - in expansion, valid only 8-bit multiplexed
module pio_top
(
  // clock and reset
  input wire mclk_i,
  input wire arst_n_i,
  // apb slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  // peripheral output override
  input wire [87:0] per_oe_i,
  input wire [87:0] per_out_i,
  // pads
  input wire [87:0] pin_i,
  output wire [87:0] pin_out_o,
  output wire [87:0] pin_oe_o,
  output wire [87:0] pin_pu_o
);

  // ----------------------------------------
  // reset
  // ----------------------------------------
  wire rst_n;

  pio_rst_sync u_rst
  (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .rst_n_o(rst_n)
  );

  // ----------------------------------------
  // register state
  // ----------------------------------------
  // direction and latch bits live per group; these are gathered views
  wire [87:0] dir_vec;
  wire [87:0] lat_vec;
  reg [21:0] pu_r;
  reg pctl_r;
  reg [2:0] mode_r;

  wire mexp;
  wire force_p1;
  wire [87:0] rdval;
  wire [87:0] lock;
  wire [87:0] wr_vec;

  assign mexp = mode_r[`PIO_MODE_MEXP];

  // read selection counts outside expansion, and in expansion only when 8-bit multiplexed
  assign force_p1 = pctl_r & (~mexp | (mode_r[`PIO_MODE_BUS8] & mode_r[`PIO_MODE_P1MUX]));

  // bus pins freeze in expansion mode
  assign lock = mexp ? `PIO_EXTBUS_MASK : 88'h00_0000_0000_0000_0000_0000;

  assign wr_vec = {`PIO_NGRP{pwdata_i[7:0]}};

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire [1:0] region;
  wire [3:0] idx;
  wire grp_ok;
  wire misc_pu;
  wire misc_pctl;
  wire misc_mode;
  wire mapped;
  wire setup;
  wire wr_go;

  // answer states: one wait state, then a single pready cycle
  localparam ST_IDLE = 1'b0;
  localparam ST_ANSWER = 1'b1;

  reg state_r;
  reg state_nxt;

  assign region = paddr_i[7:6];
  assign idx = paddr_i[5:2];
  assign grp_ok = (paddr_i[11:8] == 4'h0) & (paddr_i[1:0] == 2'b00) & (idx < 4'd11);
  assign misc_pu = (paddr_i == {4'h0, `PIO_PU_ADDR});
  assign misc_pctl = (paddr_i == {4'h0, `PIO_PCTL_ADDR});
  assign misc_mode = (paddr_i == {4'h0, `PIO_MODE_ADDR});
  assign mapped = (grp_ok & ((region == `PIO_REGION_DIR) | (region == `PIO_REGION_LAT)))
                | misc_pu | misc_pctl | misc_mode;

  // first access cycle (penable high, state idle): pready rises on the following edge
  assign setup = psel_i & penable_i & (state_r == ST_IDLE);

  // a write lands at the edge where pready is sampled high
  assign wr_go = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;

  // ----------------------------------------
  // per-group direction and latch registers
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < `PIO_NGRP; g = g + 1)
    begin : grp
      wire hit_dir;
      wire hit_lat;
      wire [7:0] dmask;
      wire [7:0] lmask;
      reg [7:0] dir_grp_r;
      reg [7:0] lat_grp_r;

      assign hit_dir = wr_go & grp_ok & (region == `PIO_REGION_DIR) & (idx == g);
      assign hit_lat = wr_go & grp_ok & (region == `PIO_REGION_LAT) & (idx == g);

      // the input-only pin has no writable direction bit
      assign dmask = ~lock[g*8 +: 8] & ((g == `PIO_IN_ONLY / 8) ? ~(8'h01 << (`PIO_IN_ONLY % 8)) : 8'hFF);
      assign lmask = ~lock[g*8 +: 8];

      // each group owns its flops, so no bit has two drivers
      assign dir_vec[g*8 +: 8] = dir_grp_r;
      assign lat_vec[g*8 +: 8] = lat_grp_r;

      // one bit per pin, reset to input
      always @(posedge mclk_i or negedge rst_n)
      begin
        if (!rst_n)
        begin
          dir_grp_r <= `PIO_DIR_RST;
          lat_grp_r <= `PIO_LAT_RST;
        end
        else
        begin
          if (hit_dir)
            dir_grp_r <= (dir_grp_r & ~dmask) | (wr_vec[g*8 +: 8] & dmask);
          if (hit_lat)
            lat_grp_r <= (lat_grp_r & ~lmask) | (wr_vec[g*8 +: 8] & lmask);
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // misc registers
  // ----------------------------------------
  // pull-up bits stay writable even when disconnected
  always @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pu_r <= `PIO_PU_RST;
      pctl_r <= `PIO_PCTL_RST;
      mode_r <= `PIO_MODE_RST;
    end
    else if (wr_go)
    begin
      if (misc_pu)
        pu_r <= pwdata_i[21:0];
      if (misc_pctl)
        pctl_r <= pwdata_i[`PIO_PCTL_P1LAT];
      if (misc_mode)
        mode_r <= pwdata_i[2:0];
    end
  end

  // ----------------------------------------
  // pin cells
  // ----------------------------------------
  wire [21:0] pu_eff;

  // expansion mode disconnects pull-ups on the bus groups except pull-up bit 9 (pins 36 to 39)
  assign pu_eff = pu_r & ~(mexp ? `PIO_PU_INV_MASK : 22'h00_0000);

  genvar p;
  generate
    for (p = 0; p < `PIO_NPIN; p = p + 1)
    begin : pin
      pio_pin_cell
      #(
        .INPUT_ONLY(p == `PIO_IN_ONLY)
      )
      u_cell
      (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n),
        .dir_i(dir_vec[p]),
        .lat_i(lat_vec[p]),
        .pu_en_i(pu_eff[p/4]),
        .force_lat_i(((p / 8) == `PIO_PORT_ONE) ? force_p1 : 1'b0),
        .per_oe_i(per_oe_i[p]),
        .per_out_i(per_out_i[p]),
        .pin_i(pin_i[p]),
        .pad_out_o(pin_out_o[p]),
        .pad_oe_o(pin_oe_o[p]),
        .pad_pu_o(pin_pu_o[p]),
        .rdval_o(rdval[p])
      );
    end
  endgenerate

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  localparam [2:0] SEL_NONE = 3'h0;
  localparam [2:0] SEL_DIR = 3'h1;
  localparam [2:0] SEL_PORT = 3'h2;
  localparam [2:0] SEL_PU = 3'h3;
  localparam [2:0] SEL_PCTL = 3'h4;
  localparam [2:0] SEL_MODE = 3'h5;

  reg [2:0] rd_sel;
  reg [31:0] rd_nxt;

  // one source per address; an unmapped address selects none
  always @*
  begin
    rd_sel = SEL_NONE;
    if (grp_ok & (region == `PIO_REGION_DIR))
      rd_sel = SEL_DIR;
    else if (grp_ok & (region == `PIO_REGION_LAT))
      rd_sel = SEL_PORT;
    else if (misc_pu)
      rd_sel = SEL_PU;
    else if (misc_pctl)
      rd_sel = SEL_PCTL;
    else if (misc_mode)
      rd_sel = SEL_MODE;
  end

  // pin level is taken at the setup edge, the same edge where pready rises
  always @*
  begin
    rd_nxt = 32'h0000_0000;
    case (rd_sel)
      SEL_DIR:
        rd_nxt = {24'h00_0000, dir_vec[{idx, 3'b000} +: 8]};
      SEL_PORT:
        rd_nxt = {24'h00_0000, rdval[{idx, 3'b000} +: 8]};
      SEL_PU:
        rd_nxt = {10'h000, pu_r};
      SEL_PCTL:
        rd_nxt = {31'h0000_0000, pctl_r};
      SEL_MODE:
        rd_nxt = {29'h0000_0000, mode_r};
      default:
        rd_nxt = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------
  // apb answer
  // ----------------------------------------
  // a new access is only taken in idle, so pready never stands two cycles
  always @*
  begin
    state_nxt = ST_IDLE;
    case (state_r)
      ST_IDLE:
        if (setup)
          state_nxt = ST_ANSWER;
      ST_ANSWER:
        state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // one wait state: simple and keeps all bus outputs registered
  always @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= ST_IDLE;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end
    else
    begin
      state_r <= state_nxt;
      pready_o <= (state_nxt == ST_ANSWER);
      pslverr_o <= setup & ~mapped;
      if (setup & ~pwrite_i)
        prdata_o <= mapped ? rd_nxt : 32'h0000_0000;
    end
  end

endmodule

// >>> testbench/pio_top_asserts.sv
`timescale 1ns/100ps
// ----------------------------------------
// port checks
// ----------------------------------------
module pio_top_asserts
(
  // clock and reset
  input wire mclk_i,
  input wire arst_n_i,
  // apb
  input wire psel_i,
  input wire penable_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  // peripheral override and pads
  input wire [87:0] per_oe_i,
  input wire [87:0] per_out_i,
  input wire [87:0] pin_out_o,
  input wire [87:0] pin_oe_o,
  input wire [87:0] pin_pu_o
);
  localparam [87:0] NO85 = ~(88'h1 << 85);
  reg [1:0] up_r;
  wire live;
  assign live = up_r == 2'h3;
  // edges since release; sync reset keeps pads quiet meanwhile
  always @(posedge mclk_i or negedge arst_n_i)
    if (!arst_n_i)
      up_r <= 2'h0;
    else if (!live)
      up_r <= up_r + 2'h1;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_acc;
    psel_i && penable_i && !pready_o;
  endsequence
  a_ack_pulse: assert property (s_acc |=> pready_o ##1 !pready_o)
    else $error("bad pready");
  a_read_hold: assert property (!pready_o |-> $stable(prdata_o))
    else $error("prdata moved");
  a_quiet_reset: assert property (!live |-> pin_oe_o == 88'h0 && pin_pu_o == 88'h0)
    else $error("pads busy in reset");
  a_pin85_oe: assert property (!pin_oe_o[85])
    else $error("pin 85 driven");
  a_pin85_pu: assert property (!pin_pu_o[85])
    else $error("pin 85 pulled");
  a_pu_input: assert property ((pin_pu_o & pin_oe_o) == 88'h0)
    else $error("pull on output");
  a_per_drive: assert property (live |=> (~pin_oe_o & $past(per_oe_i) & NO85) == 88'h0)
    else $error("override lost");
  a_per_value: assert property (live |=> ((pin_out_o ^ $past(per_out_i)) & $past(per_oe_i) & NO85) == 88'h0)
    else $error("override value");
endmodule

bind pio_top pio_top_asserts i_pio_top_asserts (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .prdata_o(prdata_o), .pready_o(pready_o), .per_oe_i(per_oe_i), .per_out_i(per_out_i),
  .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .pin_pu_o(pin_pu_o));

// >>> testbench/pio_pads_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// outside world at the pads
// ----------------------------------------
module pio_pads_model
(
  // clock
  input wire mclk_i,
  // device pad outputs
  input wire [87:0] out_i,
  input wire [87:0] oe_i,
  input wire [87:0] pu_i,
  // outside drivers
  input wire [87:0] ext_en_i,
  input wire [87:0] ext_i,
  // resolved levels
  output wire [87:0] level_o
);
  reg [87:0] flt_r = 88'h0;
  // a floating line wanders, so no stale value can pass
  always @(posedge mclk_i)
    flt_r <= ~flt_r;
  // device drive, then outside drive, then pull-up
  assign level_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_i) | (~oe_i & ~ext_en_i & (pu_i | flt_r));
endmodule

// >>> testbench/tb_pio_top.sv
`timescale 1ns/100ps
module tb_pio_top;
  reg mclk_i = 1'b0, arst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, e;
  reg [11:0] paddr_i = 12'h000;
  reg [31:0] pwdata_i = 32'h0000_0000, q;
  reg [87:0] per_oe_i = 88'h0, per_out_i = 88'h0, ext_en = 88'h0, ext_v = 88'h0;
  wire [31:0] prdata_o;
  wire pready_o, pslverr_o;
  wire [87:0] pin_out_o, pin_oe_o, pin_pu_o, pin_i;
  integer fail_count = 0, samples_checked = 0, g;
  pio_top i_pio_top (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .per_oe_i(per_oe_i), .per_out_i(per_out_i), .pin_i(pin_i), .pin_out_o(pin_out_o),
    .pin_oe_o(pin_oe_o), .pin_pu_o(pin_pu_o));
  pio_pads_model i_pio_pads_model (.mclk_i(mclk_i), .out_i(pin_out_o), .oe_i(pin_oe_o), .pu_i(pin_pu_o),
    .ext_en_i(ext_en), .ext_i(ext_v), .level_o(pin_i));
  initial
    forever #5 mclk_i = ~mclk_i;
  task give_verdict;
  begin
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
  begin
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      fail_count = fail_count + 1;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  end
  endtask
  // one apb transfer; request held until pready is sampled
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
  begin
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    n = 0;
    @(posedge mclk_i);
    while (pready_o !== 1'b1 && n < 16)
    begin
      n = n + 1;
      @(posedge mclk_i);
    end
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (n == 16)
    begin
      chk(0, 1);
      give_verdict;
    end
  end
  endtask
  task rd(input [11:0] a, input [31:0] exp);
  begin
    apb(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  end
  endtask
  // pads follow registers one edge later
  task settle;
  begin
    repeat (2) @(posedge mclk_i);
    #1;
  end
  endtask
  initial
  begin
    repeat (12) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rd(12'h080, 32'h0000_0000);
    for (g = 0; g < 11; g = g + 1)
    begin
      rd({g[9:0], 2'b00}, 32'h0000_0000);
      apb(1'b1, {g[9:0], 2'b00}, 32'h0000_00FF);
      rd({g[9:0], 2'b00}, (g == 10) ? 32'h0000_00DF : 32'h0000_00FF);
    end
    $display("test direction done");
    apb(1'b1, 12'h004, 32'h0000_00A5);
    apb(1'b1, 12'h044, 32'h0000_003C);
    apb(1'b1, 12'h080, 32'h0000_0008);
    // pin 14 is driven too, so it cannot float once expansion cuts its pull-up
    ext_en[15:8] <= 8'h5A;
    ext_v[15:8] <= 8'h4A;
    settle;
    chk(pin_oe_o[15:8], 8'hA5);
    chk(pin_pu_o[15:8], 8'h50);
    chk(pin_out_o[15:8], 8'h3C);
    rd(12'h044, 32'h0000_006E);
    apb(1'b1, 12'h084, 32'h0000_0001);
    rd(12'h044, 32'h0000_003C);
    $display("test port one done");
    apb(1'b1, 12'h088, 32'h0000_0001);
    rd(12'h044, 32'h0000_006E);
    apb(1'b1, 12'h088, 32'h0000_0007);
    rd(12'h044, 32'h0000_003C);
    apb(1'b1, 12'h000, 32'h0000_0000);
    rd(12'h000, 32'h0000_00FF);
    apb(1'b1, 12'h040, 32'h0000_0055);
    apb(1'b1, 12'h080, 32'h0020_1008);
    rd(12'h080, 32'h0020_1008);
    // group six goes to input before a peripheral takes one of its pins
    apb(1'b1, 12'h018, 32'h0000_0000);
    per_oe_i[52] <= 1'b1;
    per_out_i[52] <= 1'b1;
    per_oe_i[85] <= 1'b1;
    settle;
    chk(pin_out_o[7:0], 8'h00);
    chk(pin_pu_o[15:8], 8'h00);
    chk(pin_pu_o[55:48], 8'h0F);
    chk(pin_oe_o[55:48], 8'h10);
    chk(pin_out_o[55:48], 8'h10);
    chk(pin_oe_o[87:80], 8'hDF);
    chk(pin_pu_o[87:80], 8'h00);
    $display("test expansion done");
    apb(1'b1, 12'h0FC, 32'h0000_0001);
    chk(e, 1'b1);
    $display("test unmapped done");
    // second reset in mid-run, from a busy register state
    arst_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rd(12'h000, 32'h0000_0000);
    rd(12'h080, 32'h0000_0000);
    rd(12'h088, 32'h0000_0000);
    settle;
    chk(pin_pu_o[55:48], 8'h00);
    $display("test reset done");
    give_verdict;
  end
endmodule
